// *** rtl/dmr_regs.vh ***
// Constants for the DMA register programming block
`ifndef DMR_REGS_VH
`define DMR_REGS_VH
`define DMR_NUM_BASE 7
`define DMR_NUM_ASSOC 14
`define DMR_NUM_READ 7
// Associated register slots, in fixed load order
`define DMR_AS_A_LO 4'h0
`define DMR_AS_A_HI 4'h1
`define DMR_AS_LEN_LO 4'h2
`define DMR_AS_LEN_HI 4'h3
`define DMR_AS_A_TIM 4'h4
`define DMR_AS_B_TIM 4'h5
`define DMR_AS_MASK 4'h6
`define DMR_AS_MATCH 4'h7
`define DMR_AS_B_LO 4'h8
`define DMR_AS_B_HI 4'h9
`define DMR_AS_INTCTL 4'hA
`define DMR_AS_PULSE 4'hB
`define DMR_AS_VECTOR 4'hC
`define DMR_AS_RDMASK 4'hD
// Command group codes
`define DMR_CMD_RESET 8'hC3
`define DMR_CMD_LOAD 8'hCF
`define DMR_CMD_ENABLE 8'h87
`define DMR_CMD_DISABLE 8'h83
`define DMR_CMD_RDMASK 8'hBB
`define DMR_CMD_INIT_RD 8'hA7
`define DMR_CMD_RD_STAT 8'hBF
// Field positions
`define DMR_B0_DIR 2
`define DMR_B3_STOP 2
`define DMR_B3_INTEN 5
`define DMR_IC_MATCH 0
`define DMR_IC_EOB 1
`define DMR_ST_XFER 0
`define DMR_ST_INT 3
`define DMR_ST_MATCH 4
`define DMR_ST_EOB 5
// Reset values and FIFO depth
`define DMR_RST_BYTE 8'h00
`define DMR_RST_RDMASK 8'h7F
`define DMR_FIFO_DEPTH 16
`endif

// *** rtl/dmr_sync3.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module dmr_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      dout <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit only moves once stages two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // dmr_sync3

// *** rtl/dmr_fifo.v ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module dmr_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire sys_rst,
  input wire flush,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  localparam [AW:0] FULL_CNT = D;
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst | flush) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // dmr_fifo

// *** rtl/dmr_top.v ***
// DMA control register programming, readback and transfer engine
`timescale 1ns/10ps
`include "dmr_regs.vh"

// Functional notes
// - Twenty-one writable and seven readable eight-bit registers, pairs adjacent.
// - Writable registers form seven groups: seven base plus fourteen associated.
// - Base byte holds command bits and pointer bits selecting associated regs.
// - Following writes fill selected associated registers in fixed order.
// - First group base byte recognised from data bits D0, D1 and D7.
// - First group: port A start low, high, then length low, high.
// - Fifth group: port B start, interrupt, pulse, vector; fourth: mask, match.
// - Readback order: status, byte count, port A count, port B count.
// - Successive host reads step through readback, skipping masked entries.
// - Port counters load from start registers; active one drives address.
// - Byte counter increments per transfer and is compared with length.
// - Match on a byte is flagged during the next byte's read.
// - Bus once granted is held until the operation finishes.
// - Interrupt priority follows the chain-in and chain-out links.
// - A system reset leaves the block disabled, with no request or transfer.
// - Every host write disables; only an enable command re-enables.
// - Bus requests start only while enabled; a transfer under way runs on after a disable.
// - A byte is taken only while select, io request and write are low.
// - Host starts each readback with a command and reads it fully.
module dmr_top (
  input wire core_clk,
  input wire sys_rst,
  input wire cs_n,
  input wire io_request_n,
  input wire wr_n,
  input wire rd_n,
  input wire [7:0] host_d_i,
  output reg [7:0] host_d_o,
  output reg host_d_oe,
  output wire bus_req_n_o,
  output reg bus_req_n_oe,
  input wire bus_ack_n,
  output reg [15:0] mem_addr,
  output reg mem_rd_en,
  output reg mem_wr_en,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire interrupt_chain_in,
  output wire interrupt_chain_out,
  input wire int_ack_n,
  input wire reti,
  output wire irq_n_o,
  output wire irq_n_oe,
  output wire dma_enabled
);
  localparam ST_IDLE = 3'd0;
  localparam ST_REQ = 3'd1;
  localparam ST_RD = 3'd2;
  localparam ST_WAIT = 3'd3;
  localparam ST_CAP = 3'd4;
  localparam ST_WR = 3'd5;
  localparam ST_REL = 3'd6;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function [2:0] grp_of;
    input [7:0] b;
    begin
      if (!b[7]) begin
        if (b[1:0] != 2'b00) begin
          grp_of = 3'd0;
        end else if (b[2]) begin
          grp_of = 3'd1;
        end else begin
          grp_of = 3'd2;
        end
      end else begin
        case (b[1:0])
          2'b00: grp_of = 3'd3;
          2'b01: grp_of = 3'd4;
          2'b10: grp_of = 3'd5;
          default: grp_of = 3'd6;
        endcase
      end
    end
  endfunction

  function [3:0] low_idx;
    input [13:0] p;
    integer k;
    begin
      low_idx = 4'h0;
      for (k = 13; k >= 0; k = k - 1) begin
        if (p[k]) begin
          low_idx = k[3:0];
        end
      end
    end
  endfunction

  // Next unmasked readback slot after p, wrapping
  function [2:0] next_rd;
    input [2:0] p;
    input [6:0] m;
    integer k;
    reg [2:0] c;
    reg hit;
    begin
      next_rd = p;
      hit = 1'b0;
      c = p;
      for (k = 0; k < 7; k = k + 1) begin
        c = (c == 3'd6) ? 3'd0 : c + 3'd1;
        if (m[c] && !hit) begin
          next_rd = c;
          hit = 1'b1;
        end
      end
    end
  endfunction

  function [15:0] step_addr;
    input [15:0] a;
    input [1:0] md;
    begin
      case (md)
        2'b00: step_addr = a - 16'h0001;
        2'b01: step_addr = a + 16'h0001;
        default: step_addr = a;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [15:0] pin_s;
  dmr_sync3 #(.W(16), .INIT(16'hFF7F)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .din({host_d_i, reti, interrupt_chain_in, int_ack_n, bus_ack_n,
          rd_n, wr_n, io_request_n, cs_n}),
    .dout(pin_s)
  );
  wire [7:0] d_s = pin_s[15:8];
  wire sel_s = ~pin_s[0] & ~pin_s[1];
  wire wr_act = sel_s & ~pin_s[2];
  wire rd_act = sel_s & ~pin_s[3];
  wire ack_s = ~pin_s[4];
  wire iack_s = ~pin_s[5];
  wire chain_s = pin_s[6];
  wire reti_s = pin_s[7];

  reg wr_act_r;
  reg rd_act_r;
  reg reti_r;
  wire wr_stb = wr_act & ~wr_act_r;
  wire rd_stb = rd_act & ~rd_act_r;
  wire rd_end = ~rd_act & rd_act_r;

  ////////////////////////////////////////////////////////////////////////
  // Write register file
  reg [7:0] base_r [0:`DMR_NUM_BASE-1];
  reg [7:0] assoc_r [0:`DMR_NUM_ASSOC-1];
  reg [13:0] pend_r;
  wire [2:0] grp = grp_of(d_s);
  wire [3:0] slot = low_idx(pend_r);
  wire is_base = (pend_r == 14'h0000);
  wire cmd_stb = wr_stb & is_base & (grp == 3'd6);
  integer j;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      pend_r <= 14'h0000;
      for (j = 0; j < `DMR_NUM_BASE; j = j + 1) begin
        base_r[j] <= `DMR_RST_BYTE;
      end
      for (j = 0; j < `DMR_NUM_ASSOC; j = j + 1) begin
        assoc_r[j] <= `DMR_RST_BYTE;
      end
      assoc_r[`DMR_AS_RDMASK] <= `DMR_RST_RDMASK;
    end else if (wr_stb) begin
      if (is_base) begin
        base_r[grp] <= d_s;
        case (grp)
          3'd0: pend_r[3:0] <= d_s[6:3];
          3'd1: pend_r[4] <= d_s[6];
          3'd2: pend_r[5] <= d_s[6];
          3'd3: pend_r[7:6] <= d_s[4:3];
          3'd4: pend_r[10:8] <= d_s[4:2];
          3'd6: pend_r[13] <= (d_s == `DMR_CMD_RDMASK);
          default: pend_r <= 14'h0000;
        endcase
        if (d_s == `DMR_CMD_RESET) begin
          pend_r <= 14'h0000;
        end
      end else begin
        assoc_r[slot] <= d_s;
        pend_r[slot] <= 1'b0;
        if (slot == `DMR_AS_INTCTL) begin
          pend_r[12:11] <= d_s[4:3];
        end
      end
    end
  end

  wire [1:0] mode = base_r[0][1:0];
  wire a_to_b = base_r[0][`DMR_B0_DIR];
  wire [1:0] a_md = base_r[1][5:4];
  wire [1:0] b_md = base_r[2][5:4];
  wire stop_on_match = base_r[3][`DMR_B3_STOP];
  wire int_en = base_r[3][`DMR_B3_INTEN];
  wire [7:0] cmp_mask = assoc_r[`DMR_AS_MASK];
  wire [7:0] cmp_val = assoc_r[`DMR_AS_MATCH];
  wire [7:0] intctl = assoc_r[`DMR_AS_INTCTL];
  wire [15:0] len = {assoc_r[`DMR_AS_LEN_HI], assoc_r[`DMR_AS_LEN_LO]};
  wire [15:0] a_start = {assoc_r[`DMR_AS_A_HI], assoc_r[`DMR_AS_A_LO]};
  wire [15:0] b_start = {assoc_r[`DMR_AS_B_HI], assoc_r[`DMR_AS_B_LO]};

  ////////////////////////////////////////////////////////////////////////
  // Enable state, counters and transfer engine
  reg en_r;
  reg [2:0] st_r;
  reg [15:0] a_cnt_r;
  reg [15:0] b_cnt_r;
  reg [15:0] byte_cnt_r;
  reg [15:0] rd_cnt_r;
  reg rd_done_r;
  reg done_r;
  reg eob_r;
  reg match_r;
  reg xfer_r;
  reg hit_r;
  reg have_prev_r;
  reg int_pend_r;
  reg svc_r;
  wire cmp_hit = (((mem_rdata ^ cmp_val) & ~cmp_mask) == 8'h00);
  wire new_match = (st_r == ST_CAP) & have_prev_r & hit_r;
  wire wr_mode = mode[0];
  wire load_cmd = cmd_stb & (d_s == `DMR_CMD_LOAD);

  wire f_in_ready;
  wire f_out_valid;
  wire [7:0] f_out_data;
  wire f_pop = (st_r == ST_WR) & f_out_valid;
  dmr_fifo #(.W(8), .D(`DMR_FIFO_DEPTH), .AW(4)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(load_cmd),
    .in_data(mem_rdata),
    .in_valid(st_r == ST_CAP),
    .in_ready(f_in_ready),
    .out_data(f_out_data),
    .out_valid(f_out_valid),
    .out_ready(f_pop)
  );

  always @(posedge core_clk) begin
    if (sys_rst) begin
      en_r <= 1'b0;
    end else if (wr_stb) begin
      en_r <= cmd_stb & (d_s == `DMR_CMD_ENABLE);
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      bus_req_n_oe <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      mem_wdata <= 8'h00;
      a_cnt_r <= 16'h0000;
      b_cnt_r <= 16'h0000;
      byte_cnt_r <= 16'h0000;
      rd_cnt_r <= 16'h0000;
      rd_done_r <= 1'b0;
      done_r <= 1'b0;
      eob_r <= 1'b0;
      match_r <= 1'b0;
      xfer_r <= 1'b0;
      hit_r <= 1'b0;
      have_prev_r <= 1'b0;
    end else begin
      mem_rd_en <= 1'b0;
      mem_wr_en <= 1'b0;
      if (load_cmd) begin
        a_cnt_r <= a_start;
        b_cnt_r <= b_start;
        byte_cnt_r <= 16'h0000;
        rd_cnt_r <= 16'h0000;
        rd_done_r <= 1'b0;
        done_r <= 1'b0;
        eob_r <= 1'b0;
        match_r <= 1'b0;
        have_prev_r <= 1'b0;
      end
      case (st_r)
        ST_IDLE: begin
          // Requests only start from the enabled state
          if (en_r && !done_r && !wr_act) begin
            bus_req_n_oe <= 1'b1;
            st_r <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (ack_s) begin
            st_r <= ST_RD;
          end
        end
        ST_RD: begin
          if (!rd_done_r && f_in_ready && !(stop_on_match && match_r)) begin
            mem_addr <= a_to_b ? a_cnt_r : b_cnt_r;
            mem_rd_en <= 1'b1;
            if (a_to_b) begin
              a_cnt_r <= step_addr(a_cnt_r, a_md);
            end else begin
              b_cnt_r <= step_addr(b_cnt_r, b_md);
            end
            rd_done_r <= (rd_cnt_r == len);
            rd_cnt_r <= rd_cnt_r + 16'h0001;
            st_r <= ST_WAIT;
          end else if (f_out_valid) begin
            st_r <= ST_WR;
          end else begin
            st_r <= ST_REL;
          end
        end
        ST_WAIT: begin
          st_r <= ST_CAP;
        end
        ST_CAP: begin
          // Compare lags one byte; the flag shows on the next read
          hit_r <= cmp_hit;
          have_prev_r <= 1'b1;
          if (new_match && mode[1]) begin
            match_r <= 1'b1;
          end
          st_r <= ST_RD;
        end
        ST_WR: begin
          if (f_out_valid) begin
            mem_addr <= a_to_b ? b_cnt_r : a_cnt_r;
            mem_wdata <= f_out_data;
            mem_wr_en <= wr_mode;
            if (wr_mode && a_to_b) begin
              b_cnt_r <= step_addr(b_cnt_r, b_md);
            end else if (wr_mode) begin
              a_cnt_r <= step_addr(a_cnt_r, a_md);
            end
            byte_cnt_r <= byte_cnt_r + 16'h0001;
            xfer_r <= 1'b1;
            if (byte_cnt_r == len) begin
              eob_r <= 1'b1;
            end
          end
          st_r <= ST_RD;
        end
        ST_REL: begin
          // Bus is dropped only here, after all data has drained
          bus_req_n_oe <= 1'b0;
          done_r <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign bus_req_n_o = 1'b0;
  assign dma_enabled = en_r;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pending and daisy chain
  wire eob_evt = (st_r == ST_WR) & f_out_valid & (byte_cnt_r == len);
  wire int_evt = int_en & ((eob_evt & intctl[`DMR_IC_EOB]) |
                 (new_match & intctl[`DMR_IC_MATCH]));
  wire irq_act = int_pend_r & chain_s & ~svc_r;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      int_pend_r <= 1'b0;
      svc_r <= 1'b0;
      reti_r <= 1'b0;
    end else begin
      reti_r <= reti_s;
      // A new event beats the acknowledge that clears it
      if (int_evt) begin
        int_pend_r <= 1'b1;
      end else if (iack_s && irq_act) begin
        int_pend_r <= 1'b0;
      end
      if (iack_s && irq_act) begin
        svc_r <= 1'b1;
      end else if (reti_s && !reti_r) begin
        svc_r <= 1'b0;
      end
    end
  end

  assign interrupt_chain_out = chain_s & ~svc_r;
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_act;

  ////////////////////////////////////////////////////////////////////////
  // Readback sequence
  reg [2:0] rptr_r;
  reg stat_only_r;
  wire [6:0] rmask = stat_only_r ? 7'h01 : assoc_r[`DMR_AS_RDMASK][6:0];
  wire [7:0] status = {2'b00, ~eob_r, ~match_r, ~int_pend_r, 2'b00,
                       xfer_r};
  reg [7:0] rd_val;

  always @* begin
    case (rptr_r)
      3'd0: rd_val = status;
      3'd1: rd_val = byte_cnt_r[7:0];
      3'd2: rd_val = byte_cnt_r[15:8];
      3'd3: rd_val = a_cnt_r[7:0];
      3'd4: rd_val = a_cnt_r[15:8];
      3'd5: rd_val = b_cnt_r[7:0];
      default: rd_val = b_cnt_r[15:8];
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      rptr_r <= 3'd0;
      stat_only_r <= 1'b0;
      host_d_o <= 8'h00;
      host_d_oe <= 1'b0;
    end else begin
      wr_act_r <= wr_act;
      rd_act_r <= rd_act;
      host_d_oe <= rd_act;
      if (rd_stb) begin
        host_d_o <= rd_val;
      end
      if (cmd_stb && d_s == `DMR_CMD_INIT_RD) begin
        stat_only_r <= 1'b0;
        rptr_r <= next_rd(3'd6, assoc_r[`DMR_AS_RDMASK][6:0]);
      end else if (cmd_stb && d_s == `DMR_CMD_RD_STAT) begin
        stat_only_r <= 1'b1;
        rptr_r <= 3'd0;
      end else if (rd_end) begin
        rptr_r <= next_rd(rptr_r, rmask);
      end
    end
  end
endmodule // dmr_top

// *** verif/dmr_top_checker.sv ***
// Assertion checker for the DMA register programming block
`timescale 1ns/10ps
`include "dmr_regs.vh"
module dmr_top_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire cs_n,
  input wire io_request_n,
  input wire wr_n,
  input wire rd_n,
  input wire [7:0] host_d_i,
  input wire host_d_oe,
  input wire bus_req_n_oe,
  input wire bus_ack_n,
  input wire mem_rd_en,
  input wire mem_wr_en,
  input wire interrupt_chain_in,
  input wire interrupt_chain_out,
  input wire dma_enabled
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Reset is watched on its own, the default disable would hide it
  reset_idle_a: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> !dma_enabled && !bus_req_n_oe && !mem_rd_en && !mem_wr_en)
    else $error("outputs active after reset");
  req_when_enabled_a: assert property ($rose(bus_req_n_oe) |-> dma_enabled)
    else $error("bus request while disabled");
  strobe_granted_a: assert property ((mem_rd_en || mem_wr_en)
    |-> !bus_ack_n && bus_req_n_oe)
    else $error("memory strobe without bus");
  bus_held_a: assert property (mem_rd_en |=> bus_req_n_oe [*2])
    else $error("bus released mid transfer");
  write_disables_a: assert property (($fell(wr_n) && !cs_n &&
    !io_request_n && host_d_i != `DMR_CMD_ENABLE) |-> ##[1:8] !dma_enabled)
    else $error("host write left block enabled");
  enable_cmd_a: assert property ($rose(dma_enabled)
    |-> host_d_i == `DMR_CMD_ENABLE)
    else $error("enabled without enable command");
  read_oe_a: assert property (rd_n [*6] |-> !host_d_oe)
    else $error("data driven with no read");
  chain_block_a: assert property (!interrupt_chain_in [*6]
    |-> !interrupt_chain_out)
    else $error("chain out high with chain in low");
  cover property ($rose(dma_enabled));
  cover property ($fell(bus_req_n_oe));
  cover property ($rose(host_d_oe));
  cover property (mem_wr_en);
endmodule // dmr_top_checker

bind dmr_top dmr_top_checker i_chk (
  .core_clk, .sys_rst, .cs_n, .io_request_n, .wr_n, .rd_n, .host_d_i,
  .host_d_oe, .bus_req_n_oe, .bus_ack_n, .mem_rd_en, .mem_wr_en,
  .interrupt_chain_in, .interrupt_chain_out, .dma_enabled
);

// *** verif/dmr_sys_model.sv ***
// System bus arbiter and memory model on the transfer side
`timescale 1ns/10ps
module dmr_sys_model (
  input wire core_clk,
  input wire slow,
  input wire bus_req_n_oe,
  output reg bus_ack_n,
  input wire [15:0] mem_addr,
  input wire mem_rd_en,
  input wire mem_wr_en,
  input wire [7:0] mem_wdata,
  output wire [7:0] mem_rdata
);
  reg [15:0] wr_addr [0:63];
  reg [7:0] wr_data [0:63];
  integer wr_cnt = 0;
  integer wait_cnt = 0;
  reg [7:0] rd_byte_r = 8'h00;
  reg [7:0] noise_r = 8'h00;
  reg [1:0] rd_age_r = 2'h0;
  initial bus_ack_n = 1'b1;
  // Outside the valid window the data lines churn, so a late sample shows
  assign mem_rdata = (rd_age_r != 2'h0) ? rd_byte_r : noise_r;
  always @(posedge core_clk) begin
    noise_r <= noise_r ^ 8'h5A;
    if (mem_rd_en) begin
      rd_byte_r <= mem_addr[7:0] ^ 8'hA5;
      rd_age_r <= 2'h2;
    end else if (rd_age_r != 2'h0) begin
      rd_age_r <= rd_age_r - 2'h1;
    end
    if (mem_wr_en) begin
      wr_addr[wr_cnt[5:0]] <= mem_addr;
      wr_data[wr_cnt[5:0]] <= mem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    // Pulled up while nobody asks; grant comes late when slow is set
    if (!bus_req_n_oe) begin
      bus_ack_n <= 1'b1;
      wait_cnt <= 0;
    end else if (wait_cnt >= (slow ? 9 : 1)) begin
      bus_ack_n <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule // dmr_sys_model

// *** verif/tb.sv ***
// Testbench for the DMA register programming block
`timescale 1ns/10ps
`include "dmr_regs.vh"
module tb;
  reg core_clk, sys_rst, cs_n, io_request_n, wr_n, rd_n, chain_in, slow;
  reg int_ack_n, reti;
  wire irq_oe;
  reg [7:0] host_d_i;
  wire [7:0] host_d_o, mem_wdata, mem_rdata;
  wire [15:0] mem_addr;
  wire host_d_oe, bus_req_n_oe, bus_ack_n, mem_rd_en, mem_wr_en;
  wire chain_out, dma_enabled;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  reg [7:0] v;
  dmr_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
    .io_request_n(io_request_n), .wr_n(wr_n), .rd_n(rd_n),
    .host_d_i(host_d_i), .host_d_o(host_d_o), .host_d_oe(host_d_oe),
    .bus_req_n_o(), .bus_req_n_oe(bus_req_n_oe), .bus_ack_n(bus_ack_n),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .interrupt_chain_in(chain_in), .interrupt_chain_out(chain_out),
    .int_ack_n(int_ack_n), .reti(reti), .irq_n_o(), .irq_n_oe(irq_oe),
    .dma_enabled(dma_enabled));
  dmr_sys_model i_mem (.core_clk(core_clk), .slow(slow),
    .bus_req_n_oe(bus_req_n_oe), .bus_ack_n(bus_ack_n), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Strobes held six cycles each way to clear the input synchronisers
  task wr(input [7:0] b);
    begin
      @(negedge core_clk);
      host_d_i = b;
      {cs_n, io_request_n, wr_n} = 3'b000;
      repeat (6) @(negedge core_clk);
      {cs_n, io_request_n, wr_n} = 3'b111;
      repeat (6) @(negedge core_clk);
    end
  endtask
  task rd(output [7:0] b);
    begin
      @(negedge core_clk);
      {cs_n, io_request_n, rd_n} = 3'b000;
      repeat (6) @(negedge core_clk);
      b = host_d_o;
      {cs_n, io_request_n, rd_n} = 3'b111;
      repeat (6) @(negedge core_clk);
    end
  endtask
  // Full readback, lowest byte of e is the status byte
  task read_seq(input [55:0] e);
    integer k;
    begin
      wr(`DMR_CMD_INIT_RD);
      for (k = 0; k < 7; k = k + 1) begin
        rd(v);
        check("readback", v, e[8*k +: 8]);
      end
    end
  endtask
  task wait_xfer(input integer n);
    integer k;
    begin
      for (k = 0; k < 3000 && (i_mem.wr_cnt < n || bus_req_n_oe); k = k + 1)
        @(negedge core_clk);
      check("bus released", bus_req_n_oe, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      check("enabled", dma_enabled, 1'b0);
      check("bus req", bus_req_n_oe, 1'b0);
      chain_in = 1'b0;
      repeat (8) @(negedge core_clk);
      check("chain out", chain_out, 1'b0);
      chain_in = 1'b1;
      repeat (8) @(negedge core_clk);
      check("chain out", chain_out, 1'b1);
    end
  endtask
  task t_program;
    begin
      wr(8'h7D);
      wr(8'h10);
      wr(8'h20);
      wr(8'h13);
      wr(8'h00);
      wr(8'h14);
      wr(8'h10);
      wr(8'h8D);
      wr(8'h00);
      wr(8'h30);
      wr(`DMR_CMD_LOAD);
      repeat (20) @(negedge core_clk);
      check("bus req", bus_req_n_oe, 1'b0);
      read_seq(56'h30_0020_1000_0038);
    end
  endtask
  // Twenty bytes overfill the sixteen-word buffer on the way through
  task t_transfer;
    begin
      wr(`DMR_CMD_ENABLE);
      check("enabled", dma_enabled, 1'b1);
      wait_xfer(20);
      for (i = 0; i < 20; i = i + 1) begin
        check("wr addr", i_mem.wr_addr[i], 16'h3000 + i);
        check("wr data", i_mem.wr_data[i], (8'h10 + i) ^ 8'hA5);
      end
      check("write count", i_mem.wr_cnt, 16'd20);
      wr(`DMR_CMD_RESET);
      check("enabled", dma_enabled, 1'b0);
      read_seq(56'h30_1420_2400_1419);
    end
  endtask
  task t_mask;
    begin
      wr(`DMR_CMD_RDMASK);
      wr(8'h0A);
      wr(`DMR_CMD_INIT_RD);
      rd(v);
      check("masked read", v, 8'h14);
      rd(v);
      check("masked read", v, 8'h24);
      wr(`DMR_CMD_RD_STAT);
      rd(v);
      check("status read", v, 8'h19);
    end
  endtask
  // Base byte points at A low and length low only, under a slow grant
  task t_skip;
    begin
      slow = 1'b1;
      wr(8'h2D);
      wr(8'h40);
      wr(8'h01);
      wr(`DMR_CMD_LOAD);
      wr(`DMR_CMD_ENABLE);
      wait_xfer(22);
      check("wr count", i_mem.wr_cnt, 16'd22);
      for (i = 0; i < 2; i = i + 1) begin
        check("wr addr", i_mem.wr_addr[20 + i], 16'h3000 + i);
        check("wr data", i_mem.wr_data[20 + i], (8'h40 + i) ^ 8'hA5);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Search only: byte one hits, so the flag and interrupt rise on byte two
  task t_search;
    begin
      wr(8'h06);
      wr(8'hB8);
      wr(8'h00);
      wr(8'hE5);
      wr(8'h91);
      wr(8'h01);
      wr(`DMR_CMD_LOAD);
      wr(`DMR_CMD_ENABLE);
      repeat (4) @(negedge core_clk);
      wait_xfer(0);
      check("wr count", i_mem.wr_cnt, 16'd22);
      check("irq oe", irq_oe, 1'b1);
      wr(`DMR_CMD_RD_STAT);
      rd(v);
      check("search status", v, 8'h01);
      int_ack_n = 1'b0;
      repeat (6) @(negedge core_clk);
      int_ack_n = 1'b1;
      repeat (6) @(negedge core_clk);
      check("irq oe", irq_oe, 1'b0);
      check("chain out", chain_out, 1'b0);
      reti = 1'b1;
      repeat (6) @(negedge core_clk);
      reti = 1'b0;
      repeat (6) @(negedge core_clk);
      check("chain out", chain_out, 1'b1);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    {cs_n, io_request_n, wr_n, rd_n} = 4'hF;
    host_d_i = 8'h00;
    chain_in = 1'b1;
    slow = 1'b0;
    int_ack_n = 1'b1;
    reti = 1'b0;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset;
    t_program;
    t_transfer;
    t_mask;
    t_skip;
    t_search;
    report_and_stop;
  end
  // Whole run needs about nine hundred cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    num_errors = num_errors + 1;
    report_and_stop;
  end
endmodule // tb
